/* include/uart_pins_pkg.sv */
/*
  Shared constants and carriers for the dual serial channel pin-control block:
  register offsets, bit positions, reset values and the FIFO status bundle.
  Assumes the FIFO, baud and framing logic live outside and report levels here.
*/
package uart_pins_pkg;

  localparam int CHANNELS = 2;
  localparam int LEVEL_W = 7;

  // register offsets on register_select
  localparam logic [2:0] REG_IRQ_ENABLE = 3'h1;
  localparam logic [2:0] REG_FEATURE = 3'h2;
  localparam logic [2:0] REG_LINE_CTRL = 3'h3;
  localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
  localparam logic [2:0] REG_MODEM_STATUS = 3'h6;
  localparam logic [2:0] REG_SCRATCH = 3'h7;

  // line control value that opens the enhanced feature register at REG_FEATURE
  localparam logic [7:0] FEATURE_KEY = 8'hBF;

  // field positions
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_IRQ_OUT_BIT = 3;
  localparam int MCR_LOOP_BIT = 4;
  localparam int EFR_AUTO_RTS_BIT = 6;
  localparam int IER_MODEM_BIT = 3;
  localparam int MSR_RING_EDGE_BIT = 2;
  localparam int MSR_RING_BIT = 6;

  // values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'h00;

  typedef struct packed {
    logic [LEVEL_W-1:0] rx_level;
    logic [LEVEL_W-1:0] rx_trigger;
    logic rx_timeout;
    logic rx_error;
    logic [LEVEL_W-1:0] tx_free;
    logic [LEVEL_W-1:0] tx_trigger;
    logic tx_full;
  } fifo_status_t;

endpackage

/* design/ready_flag.sv */
/*
  Active-low ready output held in a flop: a set term drives it low, a release
  term drives it high, and otherwise it keeps its level.
  Assumes synchronous set and release terms from the owning channel.
*/
`timescale 1ns/100ps
`default_nettype none

module ready_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic assert_req,
  input wire logic release_req,
  output logic ready_n
);

  // release wins so a full or erroneous FIFO never advertises service
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_n <= 1'b1;
    end else if (release_req) begin
      ready_n <= 1'b1;
    end else if (assert_req) begin
      ready_n <= 1'b0;
    end
  end

endmodule // ready_flag

`default_nettype wire

/* design/ring_detect.sv */
/*
  Ring indicator watcher: keeps the previous pin level inverted and a sticky flag that
  records a low-to-high transition until a status read clears it.
  Assumes ring_indicator_n is already synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none

module ring_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ring_indicator_n,
  input wire logic clear,
  output logic ring_level_r,
  output logic ring_edge_r
);

  logic rise;

  assign rise = ring_indicator_n & ring_level_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ring_level_r <= 1'b0;
      ring_edge_r <= 1'b0;
    end else begin
      // ring_level_r holds the active (inverted) level of the pin
      ring_level_r <= ~ring_indicator_n;
      // a new edge in the clearing cycle is kept
      ring_edge_r <= rise | (ring_edge_r & ~clear);
    end
  end

endmodule // ring_detect

`default_nettype wire

/* design/dual_uart_pin_control.sv */
/*
  Pin-level control of a two-channel serial controller: host strobe bus,
  per-channel modem control, interrupt and user outputs, request-to-send,
  local loopback routing and DMA ready outputs.
  Assumes all inputs synchronous to clk and the FIFOs reporting levels outside.
*/
// Function
// - a write puts the data and address seen while the write strobe is low into the selected register on its rise.
// - modem control bit 3 set drives the channel interrupt pin and pulls the user output low.
// - modem control bit 3 clear floats the channel interrupt pin and raises the user output.
// - after reset both user outputs are high.
// - reset returns every register and output to its reset state and keeps the serial pins idle.
// - a rising ring indicator pin raises a modem status interrupt when enabled and its level reads in modem status.
// - modem control bit 1 set drives request-to-send low, and it is high after reset.
// - request-to-send follows receive flow only when enhanced feature bit 6 enables automatic mode.
// - in local loopback the receive pin is ignored and transmit data feeds the receiver.
// - receive ready goes low at the trigger level or on a receive timeout.
// - receive ready goes high when the receive FIFO is empty or holds an errored character.
// - transmit ready goes low when free space reaches the trigger level.
// - transmit ready goes high when the transmit buffer is full.
// - only the channel whose select is low answers a transfer.
// - the read strobe's fall puts the addressed register on the data bus.
`timescale 1ns/100ps
`default_nettype none

module dual_uart_pin_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [1:0] channel_select_n,
  input wire logic [2:0] register_select,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic [1:0] ring_indicator_n,
  input wire logic [1:0] rx_serial_in,
  input wire logic [1:0] tx_data_from_transmitter,
  input wire logic [1:0] rx_room_available,
  input wire uart_pins_pkg::fifo_status_t [1:0] fifo_status,
  output logic [1:0] tx_serial_out,
  output logic [1:0] rx_data_to_receiver,
  output logic [1:0] rts_n,
  output logic [1:0] channel_irq,
  output logic [1:0] channel_irq_oe,
  output logic [1:0] user_output_n,
  output logic [1:0] rx_dma_request_n,
  output logic [1:0] tx_dma_request_n
);

  ////////////////////////////////////////////////////////////////////////////
  // host strobe front end

  logic write_q_r;
  logic read_q_r;
  logic [2:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [1:0] wr_sel_r;
  logic wr_rise;
  logic rd_fall;
  logic [1:0] rd_sel;
  logic [1:0] rd_pick;
  logic [7:0] rd_val [2];

  assign wr_rise = ~write_q_r & write_strobe_n;
  assign rd_fall = read_q_r & ~read_strobe_n;
  assign rd_sel = ~channel_select_n;
  // channel A wins a read if the host selects both
  assign rd_pick = {rd_sel[1] & ~rd_sel[0], rd_sel[0]};

  // address, data and select are held from the low phase, so the host may
  // change them together with the rising strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_q_r <= 1'b1;
      read_q_r <= 1'b1;
      wr_addr_r <= 3'h0;
      wr_data_r <= uart_pins_pkg::REG_RESET;
      wr_sel_r <= 2'h0;
    end else begin
      write_q_r <= write_strobe_n;
      read_q_r <= read_strobe_n;
      if (!write_strobe_n) begin
        wr_addr_r <= register_select;
        wr_data_r <= host_data_in;
        wr_sel_r <= ~channel_select_n;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_data_out <= uart_pins_pkg::BUS_IDLE;
      host_data_oe <= 1'b0;
    end else if (rd_fall && (|rd_sel)) begin
      host_data_out <= rd_pick[0] ? rd_val[0] : rd_val[1];
      host_data_oe <= 1'b1;
    end else if (read_strobe_n || !(|rd_sel)) begin
      host_data_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel state

  genvar ci;
  generate
    for (ci = 0; ci < uart_pins_pkg::CHANNELS; ci++) begin : ch
      logic [7:0] mcr_r;
      logic [7:0] ier_r;
      logic [7:0] lcr_r;
      logic [7:0] efr_r;
      logic [7:0] scratch_r;
      logic wr_en;
      logic key_open;
      logic msr_clear;
      logic ring_level;
      logic ring_edge;
      logic irq_pending;
      logic rx_assert;
      logic rx_release;
      logic tx_assert;
      logic [7:0] msr_val;
      logic [7:0] feature_val;
      uart_pins_pkg::fifo_status_t fs;

      assign fs = fifo_status[ci];
      assign wr_en = wr_rise & wr_sel_r[ci];
      assign key_open = (lcr_r == uart_pins_pkg::FEATURE_KEY);
      assign msr_clear = rd_fall & rd_pick[ci] & (register_select == uart_pins_pkg::REG_MODEM_STATUS);
      assign irq_pending = ring_edge & ier_r[uart_pins_pkg::IER_MODEM_BIT];

      // bits for modem lines handled elsewhere read as zero
      assign msr_val = {1'b0, ring_level, 3'h0, ring_edge, 2'h0};
      assign feature_val = key_open ? efr_r : uart_pins_pkg::BUS_IDLE;
      assign rd_val[ci] =
        (register_select == uart_pins_pkg::REG_IRQ_ENABLE) ? ier_r :
        (register_select == uart_pins_pkg::REG_FEATURE) ? feature_val :
        (register_select == uart_pins_pkg::REG_LINE_CTRL) ? lcr_r :
        (register_select == uart_pins_pkg::REG_MODEM_CTRL) ? mcr_r :
        (register_select == uart_pins_pkg::REG_MODEM_STATUS) ? msr_val :
        (register_select == uart_pins_pkg::REG_SCRATCH) ? scratch_r : uart_pins_pkg::BUS_IDLE;

      // the ready terms; empty and error release win over the trigger
      assign rx_assert = (fs.rx_level >= fs.rx_trigger) | fs.rx_timeout;
      assign rx_release = (fs.rx_level == 7'h00) | fs.rx_error;
      assign tx_assert = (fs.tx_free >= fs.tx_trigger);

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mcr_r <= uart_pins_pkg::REG_RESET;
          ier_r <= uart_pins_pkg::REG_RESET;
          lcr_r <= uart_pins_pkg::REG_RESET;
          efr_r <= uart_pins_pkg::REG_RESET;
          scratch_r <= uart_pins_pkg::REG_RESET;
        end else if (wr_en) begin
          case (wr_addr_r)
            uart_pins_pkg::REG_IRQ_ENABLE: ier_r <= wr_data_r;
            uart_pins_pkg::REG_FEATURE: if (key_open) efr_r <= wr_data_r;
            uart_pins_pkg::REG_LINE_CTRL: lcr_r <= wr_data_r;
            uart_pins_pkg::REG_MODEM_CTRL: mcr_r <= wr_data_r;
            uart_pins_pkg::REG_SCRATCH: scratch_r <= wr_data_r;
            default: ;
          endcase
        end
      end

      // pins that face the line and the host interrupt, all from flops
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          user_output_n[ci] <= 1'b1;
          channel_irq[ci] <= 1'b0;
          channel_irq_oe[ci] <= 1'b0;
          rts_n[ci] <= 1'b1;
          tx_serial_out[ci] <= 1'b1;
          rx_data_to_receiver[ci] <= 1'b1;
        end else begin
          user_output_n[ci] <= ~mcr_r[uart_pins_pkg::MCR_IRQ_OUT_BIT];
          channel_irq_oe[ci] <= mcr_r[uart_pins_pkg::MCR_IRQ_OUT_BIT];
          channel_irq[ci] <= irq_pending;
          // automatic mode only ever withholds the request, never forces it
          rts_n[ci] <= ~(mcr_r[uart_pins_pkg::MCR_RTS_BIT] &
                         (~efr_r[uart_pins_pkg::EFR_AUTO_RTS_BIT] | rx_room_available[ci]));
          // loopback keeps the line marking while the receiver hears itself
          if (mcr_r[uart_pins_pkg::MCR_LOOP_BIT]) begin
            tx_serial_out[ci] <= 1'b1;
            rx_data_to_receiver[ci] <= tx_data_from_transmitter[ci];
          end else begin
            tx_serial_out[ci] <= tx_data_from_transmitter[ci];
            rx_data_to_receiver[ci] <= rx_serial_in[ci];
          end
        end
      end

      ring_detect u_ring (
        .clk(clk),
        .rst_n(rst_n),
        .ring_indicator_n(ring_indicator_n[ci]),
        .clear(msr_clear),
        .ring_level_r(ring_level),
        .ring_edge_r(ring_edge)
      );

      ready_flag u_rx_ready (
        .clk(clk),
        .rst_n(rst_n),
        .assert_req(rx_assert),
        .release_req(rx_release),
        .ready_n(rx_dma_request_n[ci])
      );

      ready_flag u_tx_ready (
        .clk(clk),
        .rst_n(rst_n),
        .assert_req(tx_assert),
        .release_req(fs.tx_full),
        .ready_n(tx_dma_request_n[ci])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_write_capture;
    wr_rise && wr_sel_r[0] && (wr_addr_r == uart_pins_pkg::REG_MODEM_CTRL)
      |=> ch[0].mcr_r == $past(wr_data_r);
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("modem control write lost");

  property p_irq_driven;
    ch[0].mcr_r[uart_pins_pkg::MCR_IRQ_OUT_BIT] |=> channel_irq_oe[0] && !user_output_n[0];
  endproperty
  a_irq_driven: assert property (p_irq_driven) else $error("interrupt pin not driven");

  property p_irq_float;
    !ch[1].mcr_r[uart_pins_pkg::MCR_IRQ_OUT_BIT] |=> !channel_irq_oe[1] && user_output_n[1];
  endproperty
  a_irq_float: assert property (p_irq_float) else $error("interrupt pin not floated");

  property p_reset_state;
    disable iff (1'b0)
    !rst_n |=> (user_output_n == 2'b11) && (rts_n == 2'b11) && (tx_serial_out == 2'b11)
      && (channel_irq_oe == 2'b00) && (rx_dma_request_n == 2'b11);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("outputs not at reset state");

  property p_ring_irq;
    $rose(ring_indicator_n[0]) && ch[0].ier_r[uart_pins_pkg::IER_MODEM_BIT] && $stable(ch[0].ier_r)
      |=> ##1 channel_irq[0];
  endproperty
  a_ring_irq: assert property (p_ring_irq) else $error("ring edge gave no interrupt");

  property p_rts_manual;
    ch[0].mcr_r[uart_pins_pkg::MCR_RTS_BIT] && !ch[0].efr_r[uart_pins_pkg::EFR_AUTO_RTS_BIT] |=> !rts_n[0];
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("request-to-send not low");

  property p_rts_auto;
    ch[0].efr_r[uart_pins_pkg::EFR_AUTO_RTS_BIT] && !rx_room_available[0] |=> rts_n[0];
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("request-to-send ignores flow");

  property p_loopback;
    ch[0].mcr_r[uart_pins_pkg::MCR_LOOP_BIT]
      |=> rx_data_to_receiver[0] == $past(tx_data_from_transmitter[0]) && tx_serial_out[0];
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback routing wrong");

  property p_rx_ready;
    ch[0].rx_assert && !ch[0].rx_release |=> !rx_dma_request_n[0];
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("receive ready not low");

  property p_rx_release;
    (fifo_status[0].rx_level == 7'h00) || fifo_status[0].rx_error |=> rx_dma_request_n[0];
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("receive ready not released");

  property p_tx_ready;
    (fifo_status[1].tx_free >= fifo_status[1].tx_trigger) && !fifo_status[1].tx_full
      |=> !tx_dma_request_n[1];
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("transmit ready not low");

  property p_tx_full;
    fifo_status[1].tx_full |=> tx_dma_request_n[1];
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("transmit ready low while full");

  property p_select_only;
    wr_rise && !wr_sel_r[1] |=> $stable(ch[1].mcr_r) && $stable(ch[1].efr_r);
  endproperty
  a_select_only: assert property (p_select_only) else $error("unselected channel written");

  property p_read_data;
    rd_fall && (rd_sel == 2'b01) && (register_select == uart_pins_pkg::REG_MODEM_CTRL)
      |=> host_data_oe && (host_data_out == $past(ch[0].mcr_r));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  c_write_mcr: cover property (wr_rise && wr_sel_r[1] && (wr_addr_r == uart_pins_pkg::REG_MODEM_CTRL));
  c_ring_irq: cover property (channel_irq[0] && channel_irq_oe[0]);
  c_loop: cover property (ch[1].mcr_r[uart_pins_pkg::MCR_LOOP_BIT] && !rx_dma_request_n[1]);
  c_msr_clear: cover property (ch[0].msr_clear && ch[0].ring_edge);

endmodule // dual_uart_pin_control

`default_nettype wire

/* tb/host_model.sv */
/*
  Host processor model on the strobe bus: one-byte write and read tasks.
  Assumes the bench calls the tasks from one process at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input wire logic clk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [1:0] channel_select_n,
  output logic [2:0] register_select,
  output logic [7:0] host_data_in
);
  initial begin
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    channel_select_n = 2'h3;
    register_select = 3'h0;
    host_data_in = 8'h00;
  end

  // address, select and data hold through the whole low phase of the strobe
  task automatic wr(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    channel_select_n <= sel;
    register_select <= a;
    host_data_in <= d;
    write_strobe_n <= 1'b0;
    @(posedge clk);
    write_strobe_n <= 1'b1;
    channel_select_n <= 2'h3;
    // a released bus must not look like it still carries the byte
    host_data_in <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] sel, input logic [2:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    channel_select_n <= sel;
    register_select <= a;
    read_strobe_n <= 1'b0;
    repeat (3) @(posedge clk);
    d = host_data_out;
    oe = host_data_oe;
    read_strobe_n <= 1'b1;
    channel_select_n <= 2'h3;
    @(posedge clk);
  endtask
endmodule // host_model

`default_nettype wire

/* tb/tb_dual_uart_pin_control.sv */
/*
  Self-checking bench for the pin-control block with a host model on the bus.
  Assumes the design's checks stand in its own files.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_dual_uart_pin_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic write_strobe_n, read_strobe_n, host_data_oe;
  logic [1:0] channel_select_n;
  logic [2:0] register_select;
  logic [7:0] host_data_in, host_data_out, d, m0, m1;
  logic [1:0] ring = 2'h3;
  logic [1:0] rx_in = 2'h0;
  logic [1:0] tx_in = 2'h0;
  logic [1:0] room = 2'h3;
  uart_pins_pkg::fifo_status_t [1:0] fs;
  logic [1:0] tx_serial_out, rx_data_to_receiver, rts_n, channel_irq, channel_irq_oe;
  logic [1:0] user_output_n, rx_dma_request_n, tx_dma_request_n, sel;
  logic oe;
  logic [6:0] t;
  logic [31:0] seed = 32'h00012BD4;
  int errors = 0;
  int checks = 0;

  always #12.5 clk = ~clk;

  host_model u_host_model (.clk(clk), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .channel_select_n(channel_select_n),
    .register_select(register_select), .host_data_in(host_data_in));

  dual_uart_pin_control u_dual_uart_pin_control (.clk(clk), .rst_n(rst_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .channel_select_n(channel_select_n), .register_select(register_select),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .ring_indicator_n(ring), .rx_serial_in(rx_in), .tx_data_from_transmitter(tx_in),
    .rx_room_available(room), .fifo_status(fs), .tx_serial_out(tx_serial_out),
    .rx_data_to_receiver(rx_data_to_receiver), .rts_n(rts_n), .channel_irq(channel_irq),
    .channel_irq_oe(channel_irq_oe), .user_output_n(user_output_n),
    .rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // user output, interrupt pin output enable and request-to-send of both channels
  function automatic logic [7:0] pins(input logic [7:0] a, input logic [7:0] b);
    return 8'({~b[3], ~a[3], b[3], a[3], ~b[1], ~a[1]});
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic fifo(input logic [6:0] rl, rt, input logic to, er, input logic [6:0] tf, tt, input logic fu);
    fs[0] <= {rl, rt, to, er, tf, tt, fu};
    tick(3);
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fs[0] = '0;
    fs[0].tx_trigger = 7'h10;
    fs[1] = fs[0];
    tick(10);
    chk(8'({user_output_n, rts_n}), 8'h0F);
    chk(8'({channel_irq_oe, tx_serial_out, rx_data_to_receiver}), 8'h0F);
    rst_n <= 1'b1;
    tick(2);
    u_host_model.wr(2'h2, uart_pins_pkg::REG_MODEM_CTRL, 8'h0A);
    tick(2);
    chk(pins(8'h0A, 8'h00), 8'h26);
    chk(8'({user_output_n, channel_irq_oe, rts_n}), 8'h26);
    m0 = 8'h0A;
    m1 = 8'h00;
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      sel = (seed[9:8] == 2'h3) ? 2'h0 : seed[9:8];
      u_host_model.wr(sel, uart_pins_pkg::REG_MODEM_CTRL, seed[7:0] & 8'h0A);
      if (!sel[0]) m0 = seed[7:0] & 8'h0A;
      if (!sel[1]) m1 = seed[7:0] & 8'h0A;
      tick(2);
      chk(8'({user_output_n, channel_irq_oe, rts_n}), pins(m0, m1));
    end
    // read back what the random writes left in each channel
    u_host_model.rd(2'h2, uart_pins_pkg::REG_MODEM_CTRL, d, oe);
    chk(d, m0);
    u_host_model.rd(2'h1, uart_pins_pkg::REG_MODEM_CTRL, d, oe);
    chk(d, m1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      u_host_model.wr(2'h2, uart_pins_pkg::REG_SCRATCH, seed[7:0]);
      u_host_model.wr(2'h1, uart_pins_pkg::REG_SCRATCH, seed[15:8]);
      u_host_model.rd(2'h2, uart_pins_pkg::REG_SCRATCH, d, oe);
      chk(d, seed[7:0]);
      u_host_model.rd(2'h1, uart_pins_pkg::REG_SCRATCH, d, oe);
      chk(d, seed[15:8]);
    end
    u_host_model.rd(2'h1, 3'h5, d, oe);
    chk(d, 8'h00);
    chk(8'(oe), 8'h01);
    u_host_model.rd(2'h3, uart_pins_pkg::REG_SCRATCH, d, oe);
    chk(8'(oe), 8'h00);
    // loopback on A only; B keeps its pins as the reference
    u_host_model.wr(2'h2, uart_pins_pkg::REG_MODEM_CTRL, 8'h10);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      tx_in <= seed[1:0];
      rx_in <= seed[3:2];
      tick(3);
      chk(8'({rx_data_to_receiver, tx_serial_out}), 8'({seed[3], seed[0], seed[1], 1'b1}));
    end
    u_host_model.wr(2'h2, uart_pins_pkg::REG_IRQ_ENABLE, 8'h08);
    u_host_model.wr(2'h2, uart_pins_pkg::REG_MODEM_CTRL, 8'h08);
    // both pins ring, but only A has the modem status interrupt enabled
    ring <= 2'h0;
    tick(3);
    u_host_model.rd(2'h2, uart_pins_pkg::REG_MODEM_STATUS, d, oe);
    chk(d & 8'h44, 8'h40);
    chk(8'({channel_irq_oe[0], channel_irq[0]}), 8'h02);
    ring <= 2'h3;
    tick(3);
    chk(8'({channel_irq_oe[0], channel_irq[0]}), 8'h03);
    chk(8'(channel_irq[1]), 8'h00);
    u_host_model.rd(2'h2, uart_pins_pkg::REG_MODEM_STATUS, d, oe);
    chk(d & 8'h44, 8'h04);
    // automatic request-to-send only on A; B keeps the plain control bit
    u_host_model.wr(2'h0, uart_pins_pkg::REG_MODEM_CTRL, 8'h02);
    u_host_model.wr(2'h2, uart_pins_pkg::REG_LINE_CTRL, uart_pins_pkg::FEATURE_KEY);
    u_host_model.wr(2'h2, uart_pins_pkg::REG_FEATURE, 8'h40);
    u_host_model.wr(2'h2, uart_pins_pkg::REG_LINE_CTRL, 8'h00);
    room <= 2'h0;
    tick(3);
    chk(8'(rts_n), 8'h01);
    room <= 2'h3;
    tick(3);
    chk(8'(rts_n), 8'h00);
    seed = lfsr(seed);
    t = 7'(2 + seed[7:0] % 39);
    fifo(t, t, 1'b0, 1'b0, 7'h00, t, 1'b0);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0B);
    fifo(t - 7'h01, t, 1'b0, 1'b0, t, t, 1'b0);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0A);
    fifo(7'h00, t, 1'b0, 1'b0, t, t, 1'b1);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0F);
    fifo(7'h05, 7'h7F, 1'b1, 1'b0, t - 7'h01, t, 1'b0);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0B);
    fifo(7'h05, t, 1'b0, 1'b1, t, t, 1'b0);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0E);
    // channel B reaches its transmit trigger, then fills, while A holds
    fs[1].tx_free <= 7'h10;
    tick(3);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0C);
    fs[1].tx_full <= 1'b1;
    tick(3);
    chk(8'({rx_dma_request_n, tx_dma_request_n}), 8'h0E);
    rst_n <= 1'b0;
    tick(2);
    chk(8'({user_output_n, rts_n, rx_dma_request_n, tx_dma_request_n}), 8'hFF);
    rst_n <= 1'b1;
    tick(2);
    u_host_model.rd(2'h2, uart_pins_pkg::REG_SCRATCH, d, oe);
    chk(d, 8'h00);
    end_of_test();
  end

  initial begin
    tick(20000);
    errors++;
    end_of_test();
  end
endmodule // tb_dual_uart_pin_control

`default_nettype wire
